// ===== logic/hmc_control.sv
// host mode control register, functional state, interrupt routing and bulk gate
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module hmc_control #(
   parameter int DELAY_CYC = hmc_pkg::SOF_DELAY_CYC,
   parameter int FRAME_CYC = hmc_pkg::FRAME_CYC
) (
   // clock and hardware reset
   input wire logic i_mclk,
   input wire logic i_rst,
   // software reset pulse from the command logic
   input wire logic i_soft_reset,
   // register port
   input wire hmc_pkg::addr_t i_addr,
   input wire hmc_pkg::word_t i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output hmc_pkg::word_t o_rdata,
   // downstream resume signaling pin
   input wire logic i_resume_pin,
   // list engine request to process the bulk list
   input wire logic i_bulk_want,
   output logic o_bulk_go,
   // frame timing
   output logic o_sof,
   // root hub and port reset
   output logic o_hub_reset,
   output logic o_port_reset,
   // interrupts and wake-up
   output logic o_irq,
   output logic o_smi,
   output logic o_remote_wakeup
);
   import hmc_pkg::*;

   // control fields
   logic remote_wakeup_enable;
   logic wakeup_connected_flag;
   logic smi_routing_select;
   fstate_t functional_state;
   logic bulk_queue_on;

   // status and mask
   logic [INT_BITS-1:0] interrupt_status_reg;
   logic [INT_BITS-1:0] int_mask;

   // resume pin synchroniser
   logic resume_meta;
   logic resume_sync;
   logic resume_prev;

   // frame related state
   fstate_t prev_state;
   logic bulk_frame_en;
   logic hub_reset_done;
   logic sof_pulse;
   logic frame_running;

   // next values
   fstate_t next_functional_state;
   logic [INT_BITS-1:0] next_status;
   word_t next_rdata;

   // address decode
   wire wr_ctrl = i_wr && (i_addr == OFS_CONTROL);
   wire wr_stat = i_wr && (i_addr == OFS_INT_STATUS);
   wire wr_mask = i_wr && (i_addr == OFS_INT_MASK);

   // resume edge seen only on the second synchroniser stage
   wire resume_rise = resume_sync && !resume_prev;

   // entry into and exit from operational
   wire enter_oper = (functional_state == FS_OPER) && (prev_state != FS_OPER);
   wire leave_oper = (functional_state != FS_OPER);

   // control register image, upper bits always zero
   wire word_t ctrl_image = {21'h000000, remote_wakeup_enable, wakeup_connected_flag,
                             smi_routing_select, functional_state, bulk_queue_on,
                             5'h00}; // see RL18

   wire int_pending = |(interrupt_status_reg & int_mask);

   // two flops before the pin is used
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         resume_meta <= 1'b0;
         resume_sync <= 1'b0;
         resume_prev <= 1'b0;
      end else begin
         resume_meta <= i_resume_pin;
         resume_sync <= resume_meta;
         resume_prev <= resume_sync;
      end
   end

   // state field: software writes it any time, the device only from suspend
   always_comb begin
      next_functional_state = functional_state;
      if (wr_ctrl) begin
         next_functional_state = fstate_t'(i_wdata[BIT_FSTATE_HI:BIT_FSTATE_LO]); // see RL7
      end else if (functional_state == FS_SUSPEND && resume_rise) begin
         next_functional_state = FS_RESUME; // see RL9 see RL10
      end
      if (i_soft_reset) begin
         next_functional_state = FS_SUSPEND; // see RL11
      end
   end

   // control register fields
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         remote_wakeup_enable <= 1'b0;
         wakeup_connected_flag <= 1'b0; // see RL3
         smi_routing_select <= 1'b0; // see RL6
         functional_state <= FS_RESET; // see RL12
         bulk_queue_on <= 1'b0;
      end else begin
         functional_state <= next_functional_state;
         if (i_soft_reset) begin
            // routing and connected survive a software reset
            remote_wakeup_enable <= 1'b0; // see RL3 see RL6
            bulk_queue_on <= 1'b0;
         end else if (wr_ctrl) begin
            // only software touches these fields
            remote_wakeup_enable <= i_wdata[BIT_WAKE_EN]; // see RL16
            wakeup_connected_flag <= i_wdata[BIT_WAKE_CONN]; // see RL16
            smi_routing_select <= i_wdata[BIT_SMI_ROUTE];
            bulk_queue_on <= i_wdata[BIT_BULK_ON];
         end
      end
   end

   // status flags: a hardware event wins over a write-one clear in the same cycle
   always_comb begin
      next_status = interrupt_status_reg;
      if (wr_stat) begin
         next_status = next_status & ~i_wdata[INT_BITS-1:0];
      end
      if (functional_state == FS_SUSPEND && resume_rise) begin
         next_status[BIT_RESUME_DET] = 1'b1;
      end
      if (sof_pulse) begin
         next_status[BIT_FRAME_START] = 1'b1; // see RL8
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         interrupt_status_reg <= INT_RESET;
         int_mask <= INT_RESET;
      end else begin
         interrupt_status_reg <= next_status;
         if (wr_mask) begin
            int_mask <= i_wdata[INT_BITS-1:0];
         end
      end
   end

   // frame generator, restarted on every entry into operational
   hmc_frame_gen #(
      .DELAY_CYC(DELAY_CYC),
      .FRAME_CYC(FRAME_CYC)
   ) u_frame_gen (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_start(enter_oper), // see RL8
      .i_stop(leave_oper),
      .o_sof(sof_pulse),
      .o_running(frame_running)
   );

   // bulk enable takes hold at a frame boundary; a clear acts at once,
   // which is no later than the next frame as required
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         prev_state <= FS_RESET;
         bulk_frame_en <= 1'b0;
         o_bulk_go <= 1'b0;
         o_sof <= 1'b0;
      end else begin
         prev_state <= functional_state;
         if (sof_pulse) begin
            bulk_frame_en <= bulk_queue_on; // see RL13
         end else if (!bulk_queue_on) begin
            bulk_frame_en <= 1'b0; // see RL13
         end
         // the enable is looked at on every request, not cached by the engine
         o_bulk_go <= i_bulk_want && bulk_queue_on && bulk_frame_en && frame_running; // see RL14
         o_sof <= sof_pulse;
      end
   end

   // hub reset for one cycle after hardware reset, then port reset while in reset state
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_hub_reset <= 1'b1;
         hub_reset_done <= 1'b0;
         o_port_reset <= 1'b0;
      end else begin
         o_hub_reset <= 1'b0;
         hub_reset_done <= 1'b1;
         o_port_reset <= hub_reset_done && (functional_state == FS_RESET); // see RL12
      end
   end

   // interrupt routing; the wake-up enable gates only the wake-up output, not irq or smi
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_irq <= 1'b0;
         o_smi <= 1'b0;
         o_remote_wakeup <= 1'b0;
      end else begin
         o_irq <= int_pending && !smi_routing_select; // see RL2 see RL5
         o_smi <= int_pending && smi_routing_select; // see RL5
         o_remote_wakeup <= remote_wakeup_enable && interrupt_status_reg[BIT_RESUME_DET]; // see RL1
      end
   end

   // read mux, unmapped addresses read zero
   always_comb begin
      next_rdata = '0;
      if (i_rd) begin
         case (i_addr)
            OFS_CONTROL: next_rdata = ctrl_image;
            OFS_INT_STATUS: next_rdata = {28'h0000000, interrupt_status_reg};
            OFS_INT_MASK: next_rdata = {28'h0000000, int_mask};
            default: next_rdata = '0;
         endcase
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_rdata <= '0;
      end else begin
         o_rdata <= next_rdata;
      end
   end

endmodule : hmc_control

// ===== logic/hmc_frame_gen.sv
// frame generator: first start-of-frame after the delay, then one per frame
`timescale 1ns/1ps
module hmc_frame_gen #(
   parameter int DELAY_CYC = hmc_pkg::SOF_DELAY_CYC,
   parameter int FRAME_CYC = hmc_pkg::FRAME_CYC
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst,
   // control
   input wire logic i_start,
   input wire logic i_stop,
   // frame output
   output logic o_sof,
   output logic o_running
);
   import hmc_pkg::*;

   fgen_e state;
   fgen_e next_state;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic next_sof;
   wire cnt_done = (cnt == CNT_W'(1));

   // the delay and frame period share one down counter
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_sof = 1'b0;
      case (state)
         FG_IDLE: begin
            if (i_start) begin
               next_state = FG_DELAY;
               next_cnt = CNT_W'(DELAY_CYC);
            end
         end
         FG_DELAY, FG_RUN: begin
            next_cnt = cnt - CNT_W'(1);
            if (cnt_done) begin
               next_state = FG_RUN; // see RL8
               next_sof = 1'b1;
               next_cnt = CNT_W'(FRAME_CYC);
            end
         end
         default: next_state = FG_IDLE;
      endcase
      // leaving operational wins over any pending frame
      if (i_stop) begin
         next_state = FG_IDLE;
         next_sof = 1'b0;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         state <= FG_IDLE;
         cnt <= '0;
         o_sof <= 1'b0;
         o_running <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         o_sof <= next_sof;
         o_running <= (next_state == FG_RUN);
      end
   end

endmodule : hmc_frame_gen

// ===== pkg/hmc_pkg.sv
// constants, field layout and state codes of the host mode control block
// Summary of operation
// RL1: wake-up enable plus resume flag signals wake-up
// RL2: wake-up enable never gates the interrupt
// RL3: connected flag cleared by hardware reset only
// RL4: firmware sets connected flag when wake-up used
// RL5: routing bit picks normal or management interrupt
// RL6: routing bit cleared by hardware reset only
// RL7: state codes reset, resume, operational, suspend
// RL8: frames start one millisecond after entering operational
// RL9: device changes state only from suspend
// RL10: suspend moves to resume on downstream resume
// RL11: software reset enters suspend
// RL12: hardware reset enters reset, resets hub, ports
// RL13: bulk enable acts from the next frame
// RL14: bulk enable sampled before each bulk pass
// RL15: software edits bulk list only while disabled
// RL16: device alters only state and connected fields
// RL17: software writes reserved bits as zero
// RL18: upper reserved bits read zero, writes ignored
package hmc_pkg;

   typedef logic [7:0] addr_t;
   typedef logic [31:0] word_t;
   typedef logic [1:0] fstate_t;

   // register offsets
   localparam addr_t OFS_CONTROL = 8'h04;
   localparam addr_t OFS_INT_STATUS = 8'h0c;
   localparam addr_t OFS_INT_MASK = 8'h10;

   // control register field positions
   localparam int BIT_WAKE_EN = 10;
   localparam int BIT_WAKE_CONN = 9;
   localparam int BIT_SMI_ROUTE = 8;
   localparam int BIT_FSTATE_HI = 7;
   localparam int BIT_FSTATE_LO = 6;
   localparam int BIT_BULK_ON = 5;

   // interrupt status field positions
   localparam int BIT_RESUME_DET = 3;
   localparam int BIT_FRAME_START = 2;
   localparam int INT_BITS = 4;
   localparam logic [INT_BITS-1:0] INT_RESET = 4'h0;

   // functional state codes
   localparam fstate_t FS_RESET = 2'h0;
   localparam fstate_t FS_RESUME = 2'h1;
   localparam fstate_t FS_OPER = 2'h2;
   localparam fstate_t FS_SUSPEND = 2'h3;

   // timing: clock rate and start-of-frame delay
   localparam int CLK_MHZ = 125;
   localparam int SOF_DELAY_US = 1000;
   localparam int SOF_DELAY_CYC = SOF_DELAY_US * CLK_MHZ;
   localparam int FRAME_US = 1000;
   localparam int FRAME_CYC = FRAME_US * CLK_MHZ;
   localparam int CNT_W = 17;

   // frame generator states
   typedef enum logic [2:0] {
      FG_IDLE = 3'b001,
      FG_DELAY = 3'b010,
      FG_RUN = 3'b100
   } fgen_e;

endpackage : hmc_pkg

// ===== tb/hmc_chk.sv
// checker on the ports of the host mode control block
`timescale 1ns/1ps
module hmc_chk #(
   parameter int DELAY_CYC = hmc_pkg::SOF_DELAY_CYC,
   parameter int FRAME_CYC = hmc_pkg::FRAME_CYC
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_soft_reset,
   // register port and bulk request
   input wire hmc_pkg::addr_t i_addr,
   input wire logic i_rd,
   input wire logic i_bulk_want,
   // watched outputs
   input wire hmc_pkg::word_t o_rdata,
   input wire logic o_bulk_go,
   input wire logic o_sof,
   input wire logic o_hub_reset,
   input wire logic o_port_reset,
   input wire logic o_irq,
   input wire logic o_smi
);
   import hmc_pkg::*;
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   // a read of one address answered in this cycle
   sequence rd_at(addr_t a);
      $past(i_rd) && $past(i_addr) == a;
   endsequence
   // routing never sends an event to both of the two lines
   irq_smi_excl_a: assert property (!(o_irq && o_smi))
      else $error("irq and smi high together");
   sof_pulse_a: assert property (o_sof |=> !o_sof)
      else $error("frame start longer than one cycle");
   port_after_hub_a: assert property (o_port_reset |-> !o_hub_reset)
      else $error("port reset before hub reset done");
   bulk_cause_a: assert property (o_bulk_go |-> $past(i_bulk_want))
      else $error("bulk grant without request");
   rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
      else $error("read data outside read answer");
   ctl_resv_a: assert property (rd_at(OFS_CONTROL) |-> o_rdata[31:11] == 0 && o_rdata[4:0] == 0)
      else $error("control reserved bits not zero");
   unmapped_zero_a: assert property (rd_at(8'h08) |-> o_rdata == 32'h0)
      else $error("unmapped read not zero");
   soft_suspend_a: assert property (i_soft_reset |-> ##[1:3] !o_port_reset)
      else $error("soft reset left port reset on");
endmodule : hmc_chk

bind hmc_control hmc_chk #(.DELAY_CYC(DELAY_CYC), .FRAME_CYC(FRAME_CYC)) hmc_chk_inst (.i_mclk, .i_rst,
   .i_soft_reset, .i_addr, .i_rd, .i_bulk_want, .o_rdata, .o_bulk_go, .o_sof, .o_hub_reset, .o_port_reset,
   .o_irq, .o_smi);

// ===== tb/tb_top.sv
// self-checking bench for the host mode control block
`timescale 1ns/1ps
module tb_top;
   import hmc_pkg::*;
   localparam int DLY = 20;
   localparam int FRM = 30;
   logic i_mclk = 0, i_rst = 1, i_soft_reset = 0, i_wr = 0, i_rd = 0, i_resume_pin = 0, i_bulk_want = 0;
   addr_t i_addr = 0;
   word_t i_wdata = 0, o_rdata;
   logic o_bulk_go, o_sof, o_hub_reset, o_port_reset, o_irq, o_smi, o_remote_wakeup;
   int n_mismatch = 0, compares = 0, n;
   // 125 MHz clock
   always #4 i_mclk = ~i_mclk;
   // short counts keep the run brief
   hmc_control #(.DELAY_CYC(DLY), .FRAME_CYC(FRM)) hmc_control_inst (.i_mclk, .i_rst, .i_soft_reset,
      .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_resume_pin, .i_bulk_want, .o_bulk_go, .o_sof,
      .o_hub_reset, .o_port_reset, .o_irq, .o_smi, .o_remote_wakeup);
   task automatic end_of_test;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_of_test
   task automatic chk_word(word_t got, word_t exp, string m);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk_word
   task automatic chk_bit(logic got, logic exp, string m);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t %s", $time, m);
      end
   endtask : chk_bit
   task automatic cyc(int k);
      repeat (k) @(posedge i_mclk);
      #1;
   endtask : cyc
   // bus cycles: strobe for one edge, read data taken in the cycle after
   task automatic wr(addr_t a, word_t v);
      @(posedge i_mclk);
      i_wr <= 1;
      i_addr <= a;
      i_wdata <= v;
      @(posedge i_mclk);
      i_wr <= 0;
   endtask : wr
   task automatic rd(addr_t a, word_t e);
      @(posedge i_mclk);
      i_rd <= 1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 0;
      #1 chk_word(o_rdata, e, "read");
   endtask : rd
   // counts edges until the next frame start, bounded
   task automatic wait_sof(output int k);
      k = 0;
      do begin
         @(posedge i_mclk);
         #1 k++;
      end while (o_sof !== 1'b1 && k < 200);
   endtask : wait_sof
   task automatic bulk_try(logic e);
      @(posedge i_mclk);
      i_bulk_want <= 1;
      @(posedge i_mclk);
      i_bulk_want <= 0;
      #1 chk_bit(o_bulk_go, e, "bulk gate");
   endtask : bulk_try
   task automatic t_reset;
      chk_bit(o_hub_reset, 1, "hub reset in reset");
      @(posedge i_mclk);
      i_rst <= 0;
      cyc(4);
      chk_bit(o_hub_reset, 0, "hub reset released");
      chk_bit(o_port_reset, 1, "port reset");
      rd(OFS_CONTROL, 32'h0);
      wr(8'h08, 32'hffff_ffff);
      rd(8'h08, 32'h0);
      rd(OFS_INT_STATUS, 32'h0);
      rd(OFS_INT_MASK, 32'h0);
      $display("test reset done");
   endtask : t_reset
   task automatic t_fields;
      wr(OFS_CONTROL, 32'hffff_ff3f);
      rd(OFS_CONTROL, 32'h0000_0720);
      for (int s = 0; s < 4; s++) begin
         wr(OFS_CONTROL, word_t'(s) << 6);
         rd(OFS_CONTROL, word_t'(s) << 6);
      end
      $display("test fields done");
   endtask : t_fields
   task automatic t_sof_bulk;
      wr(OFS_INT_STATUS, 32'hf);
      wr(OFS_CONTROL, 32'h80);
      wait_sof(n);
      chk_bit(n >= DLY && n <= DLY + 5, 1, "first frame delay");
      wait_sof(n);
      chk_bit(n == FRM, 1, "frame spacing");
      rd(OFS_INT_STATUS, 32'h4);
      wr(OFS_CONTROL, 32'ha0);
      bulk_try(0);
      wait_sof(n);
      bulk_try(1);
      bulk_try(1);
      // the list may only be edited once the bulk enable is off
      wr(OFS_CONTROL, 32'h80);
      bulk_try(0);
      $display("test frames and bulk done");
   endtask : t_sof_bulk
   task automatic t_wake;
      @(posedge i_mclk);
      i_resume_pin <= 1;
      cyc(8);
      rd(OFS_CONTROL, 32'h80);
      @(posedge i_mclk);
      i_resume_pin <= 0;
      wr(OFS_CONTROL, 32'hc0);
      i_resume_pin <= 1;
      cyc(8);
      rd(OFS_CONTROL, 32'h40);
      rd(OFS_INT_STATUS, 32'hc);
      @(posedge i_mclk);
      i_resume_pin <= 0;
      wr(OFS_INT_MASK, 32'h8);
      cyc(3);
      chk_bit(o_irq, 1, "normal interrupt");
      chk_bit(o_remote_wakeup, 0, "no wake without enable");
      wr(OFS_CONTROL, 32'h440);
      cyc(3);
      chk_bit(o_remote_wakeup, 1, "wake signaled");
      chk_bit(o_irq, 1, "interrupt kept");
      wr(OFS_CONTROL, 32'h540);
      cyc(3);
      chk_bit(o_smi, 1, "management interrupt");
      chk_bit(o_irq, 0, "normal interrupt off");
      wr(OFS_INT_STATUS, 32'h8);
      cyc(3);
      chk_bit(o_smi | o_remote_wakeup, 0, "cleared");
      $display("test wake and routing done");
   endtask : t_wake
   task automatic t_soft;
      wr(OFS_CONTROL, 32'h7a0);
      i_soft_reset <= 1;
      @(posedge i_mclk);
      i_soft_reset <= 0;
      rd(OFS_CONTROL, 32'h3c0);
      @(posedge i_mclk);
      i_rst <= 1;
      repeat (2) @(posedge i_mclk);
      i_rst <= 0;
      rd(OFS_CONTROL, 32'h0);
      cyc(4);
      chk_bit(o_port_reset, 1, "port reset after reset");
      // a software reset out of the reset state must end port reset
      @(posedge i_mclk);
      i_soft_reset <= 1;
      @(posedge i_mclk);
      i_soft_reset <= 0;
      rd(OFS_CONTROL, 32'h0c0);
      chk_bit(o_port_reset, 0, "port reset left after soft reset");
      $display("test soft reset done");
   endtask : t_soft
   // main sequence
   initial begin
      cyc(10);
      t_reset();
      t_fields();
      t_sof_bulk();
      t_wake();
      t_soft();
      end_of_test();
   end
   // watchdog well beyond the expected run
   initial begin
      #40000;
      n_mismatch++;
      $display("BAD %0t watchdog", $time);
      end_of_test();
   end
endmodule : tb_top
